// ### core/uss_pkg.sv
package uss_pkg;
    typedef enum logic {USS_TX_IDLE, USS_TX_SHIFT} uss_tx_state_e;
    typedef logic [8:0] uss_word_t;
endpackage

// ### core/uss_regs.svh
// Behaviour
// - Slave transfers behave exactly like master ones except sleep and clock source.
// - With words waiting, the first moves into the transmit shifter at once and shifts.
// - The second word waits in the transmit holding register meanwhile.
// - Transmit-ready stays clear while the holding register is occupied.
// - When the shifter empties, the waiting word is loaded, then transmit-ready sets.
// - Transmit-ready with its enable raises the waking interrupt.
// - Single-word receive enable is ignored; only continuous receive enables reception.
// - With continuous receive on, a finished word moves from shifter into receive buffer.
// - A word reaching the receive buffer with its enable raises the waking interrupt.
// - Receive-ready sets when a word is complete; interrupt only when enabled.
// - Clearing continuous receive clears the overrun error flag.
// - In slave mode the shift clock comes from the external clock pin.
// - Slave mode is selected by clearing the clock source select bit.
// - Receive data is sampled at the falling edge of the shift clock.
// - A third word with full buffer sets overrun, is lost, and blocks further transfers.
`ifndef USS_REGS_SVH
`define USS_REGS_SVH

`define USS_IDX_IRQ_FLAGS   8'h0C
`define USS_IDX_RECEIVE_STATUS_CONTROL       8'h18
`define USS_IDX_TXHOLD      8'h19
`define USS_IDX_RXBUF       8'h1A
`define USS_IDX_IRQ_EN      8'h8C
`define USS_IDX_TRANSMIT_STATUS_CONTROL       8'h98
`define USS_IDX_RATE        8'h99
`define USS_IDX_IRQ_STAT    8'hA0
`define USS_IDX_IRQ_CLR     8'hA1

`define USS_RST_BYTE        8'h00
`define USS_RST_TRANSMIT_STATUS_CONTROL       8'h02
`define USS_RECEIVE_STATUS_CONTROL_WMASK     8'hF0
`define USS_TRANSMIT_STATUS_CONTROL_WMASK     8'hF5

`define USS_RC_SERIAL_PORT_ENABLE         7
`define USS_RC_RX9          6
`define USS_RC_SINGLE_RX_ENABLE         5
`define USS_RC_CONTINUOUS_RX_ENABLE         4
`define USS_RC_OVERRUN_ERROR         1
`define USS_RC_RX_NINTH_BIT         0
`define USS_TX_CLOCK_SOURCE_SELECT         7
`define USS_TX_TX9          6
`define USS_TX_TX_ENABLE         5
`define USS_TX_SYNC         4
`define USS_TX_SHIFTER_EMPTY_FLAG         1
`define USS_TX_TX_NINTH_BIT         0
`define USS_IRQ_RX          5
`define USS_IRQ_TX          4

`define USS_BITS8           4'h8
`define USS_BITS9           4'h9
`define USS_SYNC_STAGES     2

`endif

// ### core/uss_rx_fifo.sv
`timescale 1ns/100ps
module uss_rx_fifo
    import uss_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      push,
    input  wire uss_word_t wdata,
    input  wire logic      pop,
    output logic           full,
    output logic           empty,
    output uss_word_t      head_q
);
    uss_word_t  mem_q [0:1];
    logic       wp_q;
    logic       rp_q;
    logic [1:0] cnt_q;
    uss_word_t  head_d;
    logic       take_new;
    logic       take_next;

    assign full      = cnt_q == 2'h2;
    assign empty     = cnt_q == 2'h0;
    assign take_new  = push && (empty || (cnt_q == 2'h1 && pop));
    assign take_next = pop && full;
    assign head_d    = take_new ? wdata : (take_next ? mem_q[~rp_q] : head_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
            head_q   <= '0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= wdata;
                wp_q        <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q  <= cnt_q + {1'b0, push} - {1'b0, pop};
            head_q <= head_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    no_push_full_a: assert property (full |-> !push) else $error("push into full receive buffer");
    no_pop_empty_a: assert property (empty |-> !pop) else $error("pop from empty receive buffer");
endmodule

// ### core/uss_sync.sv
`timescale 1ns/100ps
module uss_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ### core/uss_top.sv
`timescale 1ns/100ps
`include "uss_regs.svh"
module uss_top
    import uss_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ck_i,
    input  wire logic        dt_i,
    output logic             dt_o,
    output logic             dt_oe,
    output logic             irq
);
    // Register file.
    logic [7:0]    receive_status_control_q;
    logic [7:0]    transmit_status_control_q;
    logic [7:0]    pie_q;
    logic [7:0]    rate_q;
    logic [7:0]    stat_q;
    logic [7:0]    stat_d;
    logic [31:0]   prdata_q;

    // Link side.
    logic          ck_s;
    logic          dt_s;
    logic          ck_prev_q;
    logic          fall;
    uss_tx_state_e tx_state_q;
    uss_tx_state_e tx_state_d;
    logic [8:0]    tx_sh_q;
    logic [8:0]    tx_sh_d;
    logic [3:0]    tx_cnt_q;
    logic [3:0]    tx_cnt_d;
    logic [3:0]    tx_len_q;
    logic [7:0]    hold_q;
    logic          hold_full_q;
    logic          tx_ready_prev_q;
    logic [8:0]    rx_sh_q;
    logic [8:0]    rx_sh_new;
    logic [3:0]    rx_cnt_q;
    logic          overrun_error_q;

    // Decode wires.
    logic [7:0]    idx;
    logic          aligned;
    logic          hit_flags, hit_receive_status_control, hit_txhold, hit_rxbuf, hit_pie;
    logic          hit_transmit_status_control, hit_rate, hit_stat, hit_clr;
    logic          mapped;
    logic          setup;
    logic          access;
    logic          wr;
    logic          rd;
    logic [7:0]    rd_mux;

    // Behaviour wires.
    logic          link_on;
    logic          tx_on;
    logic          rx_on;
    logic          tx_last;
    logic          tx_load;
    logic          tx_ready;
    logic          shifter_empty_flag;
    logic [3:0]    rx_len;
    logic          rx_done;
    uss_word_t     rx_word;
    logic          push;
    logic          pop;
    logic          ovr_set;
    logic          fifo_full;
    logic          fifo_empty;
    uss_word_t     fifo_head;
    logic [7:0]    set_mask;
    logic [7:0]    clr_mask;
    logic [7:0]    flags_rd;
    logic [7:0]    receive_status_control_rd;
    logic [7:0]    transmit_status_control_rd;

    uss_sync #(.W(2)) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({ck_i, dt_i}),
        .q       ({ck_s, dt_s})
    );

    // APB decode; registers sit on word addresses four times their index.
    assign idx        = paddr[9:2];
    assign aligned    = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
    assign hit_flags  = aligned && idx == `USS_IDX_IRQ_FLAGS;
    assign hit_receive_status_control  = aligned && idx == `USS_IDX_RECEIVE_STATUS_CONTROL;
    assign hit_txhold = aligned && idx == `USS_IDX_TXHOLD;
    assign hit_rxbuf  = aligned && idx == `USS_IDX_RXBUF;
    assign hit_pie    = aligned && idx == `USS_IDX_IRQ_EN;
    assign hit_transmit_status_control  = aligned && idx == `USS_IDX_TRANSMIT_STATUS_CONTROL;
    assign hit_rate   = aligned && idx == `USS_IDX_RATE;
    assign hit_stat   = aligned && idx == `USS_IDX_IRQ_STAT;
    assign hit_clr    = aligned && idx == `USS_IDX_IRQ_CLR;
    assign mapped     = hit_flags | hit_receive_status_control | hit_txhold | hit_rxbuf | hit_pie
                      | hit_transmit_status_control | hit_rate | hit_stat | hit_clr;
    assign setup      = psel && !penable;
    assign access     = psel && penable;
    assign wr         = access && pwrite && mapped;
    assign rd         = access && !pwrite && mapped;
    assign pready     = 1'b1;
    assign pslverr    = access && !mapped;
    assign prdata     = prdata_q;

    // Mode selection.
    assign link_on  = receive_status_control_q[`USS_RC_SERIAL_PORT_ENABLE] && transmit_status_control_q[`USS_TX_SYNC] && !transmit_status_control_q[`USS_TX_CLOCK_SOURCE_SELECT];
    assign rx_on    = link_on && receive_status_control_q[`USS_RC_CONTINUOUS_RX_ENABLE];
    assign tx_on    = link_on && transmit_status_control_q[`USS_TX_TX_ENABLE] && !receive_status_control_q[`USS_RC_CONTINUOUS_RX_ENABLE];

    // The shift clock is the synchronised pin, never a local divider.
    assign fall     = ck_prev_q && !ck_s;

    // Transmit path.
    assign tx_last  = tx_cnt_q == tx_len_q - 4'h1;
    assign tx_load  = tx_on && hold_full_q && tx_state_q == USS_TX_IDLE;
    assign tx_ready = transmit_status_control_q[`USS_TX_TX_ENABLE] && !hold_full_q;
    assign shifter_empty_flag     = tx_state_q == USS_TX_IDLE;
    assign dt_o     = tx_sh_q[0];
    assign dt_oe    = tx_on;

    always_comb begin
        tx_state_d = tx_state_q;
        tx_sh_d    = tx_sh_q;
        tx_cnt_d   = tx_cnt_q;
        if (!tx_on) begin
            tx_state_d = USS_TX_IDLE;
        end else if (tx_load) begin
            tx_state_d = USS_TX_SHIFT;
            tx_sh_d    = {transmit_status_control_q[`USS_TX_TX_NINTH_BIT], hold_q};
            tx_cnt_d   = 4'h0;
        end else if (tx_state_q == USS_TX_SHIFT && fall) begin
            if (tx_last) begin
                tx_state_d = USS_TX_IDLE;
            end else begin
                tx_sh_d  = {1'b0, tx_sh_q[8:1]};
                tx_cnt_d = tx_cnt_q + 4'h1;
            end
        end
    end

    // Receive path.
    assign rx_len    = receive_status_control_q[`USS_RC_RX9] ? `USS_BITS9 : `USS_BITS8;
    assign rx_sh_new = {dt_s, rx_sh_q[8:1]};
    assign rx_done   = rx_on && fall && rx_cnt_q == rx_len - 4'h1;
    assign rx_word   = receive_status_control_q[`USS_RC_RX9] ? rx_sh_new : {1'b0, rx_sh_new[8:1]};
    assign push      = rx_done && !overrun_error_q && !fifo_full;
    assign ovr_set   = rx_done && !overrun_error_q && fifo_full;
    // Data pops on the read access; status must be read first to keep its ninth bit.
    assign pop       = rd && hit_rxbuf && !fifo_empty;

    uss_rx_fifo u_rx_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .push    (push),
        .wdata   (rx_word),
        .pop     (pop),
        .full    (fifo_full),
        .empty   (fifo_empty),
        .head_q  (fifo_head)
    );

    // Sticky events: a set in the clearing cycle wins.
    assign set_mask = {2'b00, push, tx_ready && !tx_ready_prev_q, 4'h0};
    assign clr_mask = (wr && hit_clr) ? pwdata[7:0] : 8'h00;
    assign stat_d   = (stat_q & ~clr_mask) | set_mask;
    assign irq      = |(stat_q & pie_q);

    assign flags_rd = {2'b00, !fifo_empty, tx_ready, 4'h0};
    assign receive_status_control_rd = (receive_status_control_q & `USS_RECEIVE_STATUS_CONTROL_WMASK) | {6'h00, overrun_error_q, fifo_head[8]};
    assign transmit_status_control_rd = (transmit_status_control_q & `USS_TRANSMIT_STATUS_CONTROL_WMASK) | {6'h00, shifter_empty_flag, 1'b0};
    assign rd_mux   = hit_flags ? flags_rd
                    : hit_receive_status_control ? receive_status_control_rd
                    : hit_rxbuf ? fifo_head[7:0]
                    : hit_pie   ? pie_q
                    : hit_transmit_status_control ? transmit_status_control_rd
                    : hit_rate  ? rate_q
                    : hit_stat  ? stat_q
                    : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_status_control_q  <= `USS_RST_BYTE;
            transmit_status_control_q  <= `USS_RST_TRANSMIT_STATUS_CONTROL & `USS_TRANSMIT_STATUS_CONTROL_WMASK;
            pie_q    <= `USS_RST_BYTE;
            rate_q   <= `USS_RST_BYTE;
            stat_q   <= `USS_RST_BYTE;
            prdata_q <= 32'h0000_0000;
        end else begin
            stat_q <= stat_d;
            if (setup) begin
                prdata_q <= {24'h00_0000, rd_mux};
            end
            if (wr && hit_receive_status_control) begin
                receive_status_control_q <= pwdata[7:0] & `USS_RECEIVE_STATUS_CONTROL_WMASK;
            end
            if (wr && hit_transmit_status_control) begin
                transmit_status_control_q <= pwdata[7:0] & `USS_TRANSMIT_STATUS_CONTROL_WMASK;
            end
            if (wr && hit_pie) begin
                pie_q <= pwdata[7:0];
            end
            if (wr && hit_rate) begin
                rate_q <= pwdata[7:0];
            end
        end
    end

    // A write to a full holding register is dropped so a waiting word is never lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q      <= `USS_RST_BYTE;
            hold_full_q <= 1'b0;
        end else if (tx_load) begin
            hold_full_q <= 1'b0;
        end else if (wr && hit_txhold && !hold_full_q) begin
            hold_q      <= pwdata[7:0];
            hold_full_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q      <= USS_TX_IDLE;
            tx_sh_q         <= 9'h000;
            tx_cnt_q        <= 4'h0;
            tx_len_q        <= `USS_BITS8;
            tx_ready_prev_q <= 1'b0;
            ck_prev_q       <= 1'b0;
        end else begin
            tx_state_q      <= tx_state_d;
            tx_sh_q         <= tx_sh_d;
            tx_cnt_q        <= tx_cnt_d;
            tx_ready_prev_q <= tx_ready;
            ck_prev_q       <= ck_s;
            if (tx_load) begin
                tx_len_q <= transmit_status_control_q[`USS_TX_TX9] ? `USS_BITS9 : `USS_BITS8;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sh_q  <= 9'h000;
            rx_cnt_q <= 4'h0;
            overrun_error_q   <= 1'b0;
        end else begin
            if (!rx_on) begin
                rx_cnt_q <= 4'h0;
            end else if (fall) begin
                rx_sh_q  <= rx_sh_new;
                rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
            end
            if (!receive_status_control_q[`USS_RC_CONTINUOUS_RX_ENABLE]) begin
                overrun_error_q <= 1'b0;
            end else if (ovr_set) begin
                overrun_error_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    master_no_drive_a: assert property (!link_on |-> !dt_oe)
        else $error("data pin driven outside slave mode");
    first_load_a: assert property (tx_load |=> tx_state_q == USS_TX_SHIFT && dt_o == $past(hold_q[0]))
        else $error("waiting word not moved into shifter");
    second_waits_a: assert property ((tx_state_q == USS_TX_SHIFT && hold_full_q && !(fall && tx_last))
                                     |=> hold_full_q && $stable(hold_q))
        else $error("waiting word left holding register early");
    tx_flag_busy_a: assert property (hold_full_q |-> !flags_rd[`USS_IRQ_TX])
        else $error("transmit ready shown with holding register full");
    reload_flag_a: assert property ((tx_on && tx_state_q == USS_TX_SHIFT && fall && tx_last && hold_full_q)
                                    |=> ##1 tx_state_q == USS_TX_SHIFT && tx_ready)
        else $error("waiting word not reloaded after shift");
    tx_wake_a: assert property (($rose(tx_ready) && pie_q[`USS_IRQ_TX]) |=> irq)
        else $error("transmit ready did not raise interrupt");
    single_ignored_a: assert property ((receive_status_control_q[`USS_RC_SINGLE_RX_ENABLE] && !receive_status_control_q[`USS_RC_CONTINUOUS_RX_ENABLE]) |-> !push && rx_cnt_q == 4'h0)
        else $error("single receive enable started reception");
    rx_deliver_a: assert property ((rx_done && !overrun_error_q && !fifo_full) |=> !fifo_empty && flags_rd[`USS_IRQ_RX])
        else $error("finished word not in receive buffer");
    rx_wake_a: assert property ((push && pie_q[`USS_IRQ_RX]) |=> irq && stat_q[`USS_IRQ_RX])
        else $error("received word did not raise interrupt");
    rx_sticky_a: assert property (push |=> stat_q[`USS_IRQ_RX])
        else $error("receive event not recorded");
    overrun_error_clear_a: assert property (!receive_status_control_q[`USS_RC_CONTINUOUS_RX_ENABLE] |=> !overrun_error_q)
        else $error("overrun not cleared with continuous receive off");
    overrun_set_a: assert property (ovr_set |=> overrun_error_q && fifo_full ##1 !push)
        else $error("overrun not flagged or word not dropped");
    fall_sample_a: assert property ((rx_on && !fall) |=> $stable(rx_sh_q))
        else $error("receive shifter moved without falling clock edge");
    lsb_shift_a: assert property ((tx_on && tx_state_q == USS_TX_SHIFT && fall && !tx_last)
                                  |=> tx_sh_q == {1'b0, $past(tx_sh_q[8:1])})
        else $error("transmit shifter not moving least significant first");

    tx_reload_c: cover property (tx_state_q == USS_TX_SHIFT && hold_full_q ##[1:800] tx_load);
    rx_overrun_c: cover property (ovr_set);
    irq_raise_c: cover property ($rose(irq));
    rx_pop_c: cover property (pop && fifo_full);
endmodule

// ### verif/test_usart_sync_slave_mode.sv
`timescale 1ns/100ps
`include "uss_regs.svh"
module test_usart_sync_slave_mode;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ck;
    logic        m_dt;
    logic        dt_o;
    logic        dt_oe;
    logic        irq;
    wire logic   dt_line;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    logic [8:0]  rxq[$];
    logic        ovr = 1'b0;
    logic [31:0] rd;
    logic        err;
    logic [8:0]  got;
    logic [8:0]  w[4];
    logic [7:0]  ridx[8] = '{`USS_IDX_IRQ_FLAGS, `USS_IDX_RECEIVE_STATUS_CONTROL, `USS_IDX_TXHOLD, `USS_IDX_RXBUF,
                             `USS_IDX_IRQ_EN, `USS_IDX_TRANSMIT_STATUS_CONTROL, `USS_IDX_RATE, `USS_IDX_IRQ_STAT};
    logic [7:0]  rrst[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

    assign dt_line = dt_oe ? dt_o : m_dt;
    always #12.5 pclk = ~pclk;

    uss_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                   .ck_i(ck), .dt_i(dt_line), .dt_o(dt_o), .dt_oe(dt_oe), .irq(irq));
    uss_ext_master u_mst (.ck(ck), .dt_drv(m_dt), .dt_line(dt_line));

    task automatic wrap_up;
        $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_pin(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t pin got=%h exp=%h", $time, g, e);
        end
    endtask

    // The request is held until pready is seen high; an idle cycle follows so psel never toggles twice at once.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (pready !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk32(rd, {24'h00_0000, e});
    endtask

    task automatic xfer(input int nb, input logic [8:0] tx, input int slow);
        u_mst.frame(nb, tx, slow, got);
        repeat (4) @(posedge pclk);
    endtask

    function automatic void model_push(input logic [8:0] v);
        if (ovr) begin
            return;
        end
        if (rxq.size() == 2) begin
            ovr = 1'b1;
        end else begin
            rxq.push_back(v);
        end
    endfunction

    initial begin
        void'($urandom(32'hfe45_6a51));
        for (int i = 0; i < 4; i++) begin
            w[i] = 9'($urandom);
        end
        w[1][8] = w[0][8];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_pin(irq, 1'b0);
        chk_pin(dt_oe, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rdchk(ridx[i], rrst[i]);
        end
        apb(1'b0, 8'h10, 8'h00);
        chk_pin(err, 1'b1);
        chk32(rd, 32'h0000_0000);
        apb(1'b1, `USS_IDX_RATE, w[3][7:0]);
        rdchk(`USS_IDX_RATE, w[3][7:0]);

        apb(1'b1, `USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
        apb(1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'h80);
        apb(1'b1, `USS_IDX_IRQ_EN, 8'h10);
        apb(1'b1, `USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h50);
        apb(1'b1, `USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h70);
        apb(1'b1, `USS_IDX_TRANSMIT_STATUS_CONTROL, {7'h38, w[0][8]});
        rdchk(`USS_IDX_TRANSMIT_STATUS_CONTROL, {7'h39, w[0][8]});
        apb(1'b1, `USS_IDX_TXHOLD, w[0][7:0]);
        apb(1'b1, `USS_IDX_TXHOLD, w[1][7:0]);
        apb(1'b1, `USS_IDX_IRQ_CLR, 8'h30);
        rdchk(`USS_IDX_IRQ_FLAGS, 8'h00);
        chk_pin(irq, 1'b0);
        chk_pin(dt_oe, 1'b1);
        chk_pin(dt_o, w[0][0]);
        xfer(9, 9'h000, 0);
        chk32({23'h0, got}, {23'h0, w[0]});
        chk_pin(irq, 1'b1);
        rdchk(`USS_IDX_IRQ_FLAGS, 8'h10);
        xfer(9, 9'h000, 300);
        chk32({23'h0, got}, {23'h0, w[1]});
        apb(1'b1, `USS_IDX_IRQ_EN, 8'h00);
        chk_pin(irq, 1'b0);
        apb(1'b1, `USS_IDX_IRQ_CLR, 8'h10);
        rdchk(`USS_IDX_IRQ_STAT, 8'h00);

        // Single-word receive alone must not start reception in slave mode.
        apb(1'b1, `USS_IDX_TRANSMIT_STATUS_CONTROL, 8'h10);
        apb(1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'ha0);
        xfer(8, w[3], 0);
        rdchk(`USS_IDX_IRQ_FLAGS, 8'h00);
        apb(1'b1, `USS_IDX_IRQ_EN, 8'h20);
        apb(1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'hc0);
        apb(1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'hd0);
        apb(1'b1, `USS_IDX_IRQ_CLR, 8'h30);
        for (int i = 0; i < 3; i++) begin
            xfer(9, w[i], i * 100);
            model_push(w[i]);
            chk_pin(irq, 1'b1);
        end
        chk_pin(dt_oe, 1'b0);
        rdchk(`USS_IDX_IRQ_FLAGS, 8'h20);
        while (rxq.size() > 0) begin
            rdchk(`USS_IDX_RECEIVE_STATUS_CONTROL, {6'h34, ovr, rxq[0][8]});
            rdchk(`USS_IDX_RXBUF, rxq[0][7:0]);
            void'(rxq.pop_front());
        end
        xfer(9, w[3], 0);
        model_push(w[3]);
        rdchk(`USS_IDX_IRQ_FLAGS, 8'h00);
        apb(1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'hc0);
        ovr = 1'b0;
        apb(1'b0, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'h00);
        chk32(rd & 32'h0000_00fe, 32'h0000_00c0);
        apb(1'b1, `USS_IDX_RECEIVE_STATUS_CONTROL, 8'hd0);
        xfer(9, w[2], 0);
        model_push(w[2]);
        rdchk(`USS_IDX_RECEIVE_STATUS_CONTROL, {6'h34, ovr, rxq[0][8]});
        apb(1'b1, `USS_IDX_IRQ_CLR, 8'h20);
        chk_pin(irq, 1'b0);
        rdchk(`USS_IDX_RXBUF, rxq[0][7:0]);
        wrap_up();
    end
endmodule

// ### verif/uss_ext_master.sv
`timescale 1ns/100ps
module uss_ext_master (
    output logic      ck,
    output logic      dt_drv,
    input  wire logic dt_line
);
    initial begin
        ck     = 1'b1;
        dt_drv = 1'b0;
    end

    // The clock rests high between frames, so the slave sees no edge outside a frame.
    // Stretch lengthens the high phase to act as a slow master.
    task automatic frame(input int nb, input logic [8:0] tx, input int stretch, output logic [8:0] rx);
        rx = 9'h000;
        #7;
        for (int i = 0; i < nb; i++) begin
            dt_drv = tx[i];
            #(50 + stretch);
            ck    = 1'b0;
            rx[i] = dt_line;
            #100;
            ck = 1'b1;
            #50;
        end
        // A released line must not keep showing the last bit.
        dt_drv = ~dt_drv;
    endtask
endmodule
